/* File: hw/ipl_avmm_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module ipl_avmm_slave #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  ipl_bus_if.slave               bus
);
  ipl_pkg::ipl_bus_state_t state_q, state_d;
  logic [31:0] readdata_q, readdata_d;
  logic        request;

  assign request       = avs_read | avs_write;
  assign bus.idx       = avs_address[ADDR_W-1:2];
  assign bus.wdata     = avs_writedata[15:0];
  assign bus.wbe       = avs_byteenable[1:0];
  // a write lands only on the edge where the master sees waitrequest low
  assign bus.wrCommit  = ce & avs_write & (state_q == ipl_pkg::ST_ACK);
  assign avs_readdata    = readdata_q;
  // idle bit doubles as the wait flag, so the output is a bare flop
  assign avs_waitrequest = state_q[0];

  always_comb begin
    state_d    = state_q;
    readdata_d = readdata_q;
    unique case (state_q)
      ipl_pkg::ST_IDLE: begin
        if (request) begin
          state_d = ipl_pkg::ST_ACK;
          if (avs_read) begin
            readdata_d = {16'h0000, bus.rdWord};
          end
        end
      end
      ipl_pkg::ST_ACK: begin
        state_d = ipl_pkg::ST_IDLE;
      end
      default: begin
        state_d = ipl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q    <= ipl_pkg::ST_IDLE;
      readdata_q <= 32'h00000000;
    end else if (ce) begin
      state_q    <= state_d;
      readdata_q <= readdata_d;
    end
  end
endmodule : ipl_avmm_slave
`default_nettype wire

/* File: hw/ipl_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ipl_bus_if;
  logic        wrCommit;
  logic [5:0]  idx;
  logic [15:0] wdata;
  logic [1:0]  wbe;
  logic [15:0] rdWord;
  modport slave (output wrCommit, output idx, output wdata, output wbe,
                 input rdWord);
  modport regs  (input wrCommit, input idx, input wdata, input wbe,
                 output rdWord);
endinterface : ipl_bus_if
`default_nettype wire

/* File: hw/ipl_level_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module ipl_level_decode #(
  parameter int unsigned SLOTS      = 24,
  parameter logic [23:0] DEBUG_MASK = 24'h00001F
) (
  input  wire logic [2*SLOTS-1:0] fields,
  output logic [SLOTS-1:0]        enable,
  output logic [2*SLOTS-1:0]      level
);
  // returns {enable, level}; debug fields sit one level higher
  function automatic logic [2:0] decodeLevel(input logic [1:0] field,
                                             input logic       isDebug);
    logic [1:0] lvl;
    lvl = isDebug ? field : field - 2'h1;
    decodeLevel = {field != ipl_pkg::PRIO_OFF, lvl};
  endfunction : decodeLevel

  for (genvar k = 0; k < SLOTS; k++) begin : gSlot
    logic [2:0] dec;
    assign dec = decodeLevel(fields[2*k+:2], DEBUG_MASK[k]);
    assign enable[k]     = dec[2];
    assign level[2*k+:2] = dec[2] ? dec[1:0] : 2'h0;
  end
endmodule : ipl_level_decode
`default_nettype wire

/* File: hw/ipl_pkg.sv */
package ipl_pkg;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned REG_CNT   = 3;
  localparam int unsigned IDX_W     = 6;
  localparam int unsigned SLOT_CNT  = 24;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PRIO0 = 6'h00;
  localparam logic [5:0] IDX_PRIO1 = 6'h01;
  localparam logic [5:0] IDX_PRIO2 = 6'h02;
  localparam logic [15:0] RESET_PRIO = 16'h0000;
  localparam logic [15:0] WMASK0     = 16'hC3FF;
  localparam logic [15:0] WMASK1     = 16'hFCFF;
  localparam logic [15:0] WMASK2     = 16'hF3FF;
  // slot k of {reg2,reg1,reg0} is bits 2k+1:2k; slots 0-4 are debug
  localparam logic [23:0] DEBUG_SLOTS = 24'h00001F;
  localparam logic [1:0]  PRIO_OFF    = 2'h0;
  // field positions (lsb) in their register
  localparam int unsigned LOW_VOLTAGE_PRIO_LSB         = 14;
  localparam int unsigned DBG_RX_FULL_PRIO_LSB         = 8;
  localparam int unsigned DBG_TX_EMPTY_PRIO_LSB        = 6;
  localparam int unsigned DBG_TRACE_BUF_PRIO_LSB       = 4;
  localparam int unsigned DBG_BREAKPOINT_PRIO_LSB      = 2;
  localparam int unsigned DBG_STEP_COUNT_PRIO_LSB      = 0;
  localparam int unsigned PORT_B_PRIO_LSB              = 14;
  localparam int unsigned PORT_C_PRIO_LSB              = 12;
  localparam int unsigned PORT_D_PRIO_LSB              = 10;
  localparam int unsigned FLASH_BUFFERS_EMPTY_PRIO_LSB = 6;
  localparam int unsigned FLASH_CMD_DONE_PRIO_LSB      = 4;
  localparam int unsigned FLASH_ERROR_PRIO_LSB         = 2;
  localparam int unsigned CLOCK_SYNTH_PRIO_LSB         = 0;
  localparam int unsigned UART_RX_FULL_PRIO_LSB        = 14;
  localparam int unsigned UART_RX_ERROR_PRIO_LSB       = 12;
  localparam int unsigned UART_TX_IDLE_PRIO_LSB        = 8;
  localparam int unsigned UART_TX_EMPTY_PRIO_LSB       = 6;
  localparam int unsigned SYNC_SERIAL_TX_EMPTY_PRIO_LSB = 4;
  localparam int unsigned SYNC_SERIAL_RX_FULL_PRIO_LSB = 2;
  localparam int unsigned PORT_A_PRIO_LSB              = 0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } ipl_bus_state_t;
endpackage : ipl_pkg

/* File: hw/ipl_prio_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module ipl_prio_regs #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [23:0]       irqReq,
  output logic [23:0]            srcActive,
  output logic [47:0]            srcLevel
);
  localparam logic [15:0] WMASK [3] = '{ipl_pkg::WMASK0, ipl_pkg::WMASK1,
                                        ipl_pkg::WMASK2};

  ipl_bus_if bus ();

  logic [15:0] prio_q [3];
  logic [15:0] prio_d [3];
  logic [23:0] srcActive_q, srcActive_d;
  logic [47:0] srcLevel_q,  srcLevel_d;
  logic [47:0] allFields;
  logic [23:0] slotEn;
  logic [47:0] slotLvl;
  logic [15:0] byteMask;

  ipl_avmm_slave #(
    .ADDR_W (ADDR_W)
  ) uSlave (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .ce              (ce),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .bus             (bus.slave)
  );

  assign byteMask = {{8{bus.wbe[1]}}, {8{bus.wbe[0]}}};

  // register file; reserved bits never take a one
  always_comb begin
    for (int r = 0; r < 3; r++) begin
      prio_d[r] = prio_q[r];
      if (bus.wrCommit && bus.idx == 6'(r)) begin
        prio_d[r] = (prio_q[r] & ~(byteMask & WMASK[r]))
                  | (bus.wdata & byteMask & WMASK[r]);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int r = 0; r < 3; r++) begin
        prio_q[r] <= ipl_pkg::RESET_PRIO;
      end
    end else if (ce) begin
      for (int r = 0; r < 3; r++) begin
        prio_q[r] <= prio_d[r];
      end
    end
  end

  // unmapped indices read zero
  always_comb begin
    unique case (bus.idx)
      ipl_pkg::IDX_PRIO0: bus.rdWord = prio_q[0];
      ipl_pkg::IDX_PRIO1: bus.rdWord = prio_q[1];
      ipl_pkg::IDX_PRIO2: bus.rdWord = prio_q[2];
      default:            bus.rdWord = 16'h0000;
    endcase
  end

  // slots line up so fields keep their bit places within each register
  assign allFields = {prio_q[2], prio_q[1], prio_q[0]};

  ipl_level_decode #(
    .SLOTS      (ipl_pkg::SLOT_CNT),
    .DEBUG_MASK (ipl_pkg::DEBUG_SLOTS)
  ) uDecode (
    .fields (allFields),
    .enable (slotEn),
    .level  (slotLvl)
  );

  // reserved slots always decode as disabled, so their requests drop
  always_comb begin
    srcActive_d = irqReq & slotEn;
    srcLevel_d  = '0;
    for (int k = 0; k < 24; k++) begin
      if (srcActive_d[k]) begin
        srcLevel_d[2*k+:2] = slotLvl[2*k+:2];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      srcActive_q <= 24'h000000;
      srcLevel_q  <= 48'h000000000000;
    end else if (ce) begin
      srcActive_q <= srcActive_d;
      srcLevel_q  <= srcLevel_d;
    end
  end

  assign srcActive = srcActive_q;
  assign srcLevel  = srcLevel_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || !ce);

  AST_RESET_OFF: assert property (
    $fell(reset) |-> (prio_q[0] == 16'h0000 && prio_q[1] == 16'h0000
                      && prio_q[2] == 16'h0000 && srcActive_q == 24'h000000))
    else $error("priority fields not cleared by reset");

  AST_RSVD_ZERO: assert property (
    (prio_q[0] & ~ipl_pkg::WMASK0) == 16'h0000
    && (prio_q[1] & ~ipl_pkg::WMASK1) == 16'h0000
    && (prio_q[2] & ~ipl_pkg::WMASK2) == 16'h0000)
    else $error("reserved bit holds a one");

  AST_READ_UPPER_ZERO: assert property (
    !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

  AST_WRITE_REG0: assert property (
    (bus.wrCommit && bus.idx == ipl_pkg::IDX_PRIO0 && bus.wbe == 2'h3)
    |=> prio_q[0] == ($past(bus.wdata) & ipl_pkg::WMASK0))
    else $error("reg0 write not stored");

  AST_WRITE_REG1: assert property (
    (bus.wrCommit && bus.idx == ipl_pkg::IDX_PRIO1 && bus.wbe == 2'h3)
    |=> prio_q[1] == ($past(bus.wdata) & ipl_pkg::WMASK1))
    else $error("reg1 write not stored");

  AST_WRITE_REG2: assert property (
    (bus.wrCommit && bus.idx == ipl_pkg::IDX_PRIO2 && bus.wbe == 2'h3)
    |=> prio_q[2] == ($past(bus.wdata) & ipl_pkg::WMASK2))
    else $error("reg2 write not stored");

  // an edge with ce low updates nothing, so it starts no check
  AST_LVI_LEVEL: assert property (
    (ce && irqReq[7] && prio_q[0][15:14] == 2'h3)
    |=> srcActive_q[7] && srcLevel_q[15:14] == 2'h2)
    else $error("peripheral code 11 not level 2");

  AST_DBG_LEVEL: assert property (
    (ce && irqReq[4] && prio_q[0][9:8] == 2'h1)
    |=> srcActive_q[4] && srcLevel_q[9:8] == 2'h1)
    else $error("debug code 01 not level 1");

  AST_MASKED: assert property (
    ce |=> (srcActive_q & ~$past(slotEn)) == 24'h000000)
    else $error("disabled source reached arbitration");

  AST_FORWARD: assert property (
    ce |=> srcActive_q == ($past(irqReq) & $past(slotEn)))
    else $error("enabled request not forwarded");

  AST_ACK_BOUND: assert property (
    ((avs_read || avs_write) && avs_waitrequest) |-> ##[0:1] !avs_waitrequest)
    else $error("request not answered in time");

  AST_ACK_PULSE: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than a cycle");

  COV_WRITE0: cover property (bus.wrCommit && bus.idx == ipl_pkg::IDX_PRIO0);
  COV_READ2:  cover property (!avs_waitrequest && avs_read
                              && bus.idx == ipl_pkg::IDX_PRIO2);
  COV_DBG3:   cover property (srcActive_q[0] && srcLevel_q[1:0] == 2'h3);
  COV_B2B:    cover property (bus.wrCommit ##2 bus.wrCommit);
endmodule : ipl_prio_regs
`default_nettype wire

/* File: sim/ipl_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ipl_src_model (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic [23:0] pat,
  output logic      [23:0] irqReq
);
  logic [23:0] stage_q;
  // slow mode adds a cycle, as a source behind its own flop would
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage_q <= 24'h000000;
      irqReq  <= 24'h000000;
    end else begin
      stage_q <= pat;
      irqReq  <= slow ? stage_q : pat;
    end
  end
endmodule : ipl_src_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [23:0] reqPat = 24'h000000;
  logic        slow = 1'b0;
  logic        chkOn = 1'b0;
  logic [23:0] irqReq;
  logic [23:0] prevReq;
  logic [23:0] srcActive;
  logic [47:0] srcLevel;
  logic [15:0] mReg [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [31:0] rd;
  logic [71:0] hold;
  int          n_fail = 0;
  int          checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  ipl_prio_regs #(.ADDR_W(8)) uut (.clk_sys(clk_sys), .reset(reset),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irqReq(irqReq),
    .srcActive(srcActive), .srcLevel(srcLevel));
  ipl_src_model partner (.clk_sys(clk_sys), .reset(reset), .slow(slow),
    .pat(reqPat), .irqReq(irqReq));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic fail_msg(input string m);
    n_fail++;
    $display("Error %0t: %s", $time, m);
  endtask : fail_msg
  task automatic bus_op(input logic wr, input int i, input logic [15:0] d,
                        input logic [1:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address    <= 8'(i * 4);
    avs_writedata  <= {16'($urandom), d};
    avs_byteenable <= {2'($urandom), be};
    avs_write      <= wr;
    avs_read       <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 20) begin
      fail_msg("bus answer missing");
      complete_run();
    end
  endtask : bus_op
  // model keeps reserved bits zero by masking every write
  task automatic wr(input int i, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] bm;
    logic [15:0] wm;
    bm = {{8{be[1]}}, {8{be[0]}}};
    wm = (i == 0) ? 16'hC3FF : (i == 1) ? 16'hFCFF : 16'hF3FF;
    bus_op(1'b1, i, d, be, rd);
    if (i < 3) mReg[i] = (mReg[i] & ~bm) | (d & bm & wm);
  endtask : wr
  task automatic chk_word(input int i);
    logic [31:0] exp;
    bus_op(1'b0, i, 16'h0000, 2'b00, rd);
    exp = (i < 3) ? {16'h0000, mReg[i]} : 32'h00000000;
    checks++;
    if (rd !== exp) fail_msg($sformatf("read %h want %h", rd, exp));
  endtask : chk_word
  task automatic chk_irq;
    logic [47:0] f;
    logic [23:0] ea;
    logic [47:0] el;
    logic [1:0]  c;
    f = {mReg[2], mReg[1], mReg[0]};
    ea = 24'h000000;
    el = 48'h000000000000;
    for (int k = 0; k < 24; k++) begin
      c = f[2*k +: 2];
      if (prevReq[k] && c != 2'b00) begin
        ea[k] = 1'b1;
        el[2*k +: 2] = (k < 5) ? c : c - 2'b01;
      end
    end
    checks++;
    if (srcActive !== ea || srcLevel !== el) begin
      fail_msg($sformatf("irq %h/%h want %h/%h", srcActive, srcLevel,
                         ea, el));
    end
  endtask : chk_irq
  task automatic chk_hold(input logic [71:0] h);
    checks++;
    if ({srcLevel, srcActive} !== h) fail_msg("outputs moved while ce low");
  endtask : chk_hold
  always @(posedge clk_sys) prevReq <= irqReq;
  always @(negedge clk_sys) begin
    if (chkOn) chk_irq();
  end
  // checker only runs once register writes have settled
  task automatic irq_phase(input int n, input logic full);
    @(posedge clk_sys);
    chkOn <= 1'b1;
    repeat (n) begin
      @(posedge clk_sys);
      reqPat <= full ? 24'hFFFFFF : 24'($urandom);
    end
    @(posedge clk_sys);
    chkOn <= 1'b0;
  endtask : irq_phase
  initial begin
    void'($urandom(32'h7FEA38D4));
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) chk_word(i);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      wr(i, 16'hFFFF, 2'b11);
      chk_word(i);
      wr(i, 16'h0000, 2'b01);
      chk_word(i);
    end
    $display("test reserved_bits done");
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 3; i++) wr(i, 16'(16'h5555 * c), 2'b11);
      irq_phase(6, 1'b1);
      irq_phase(6, 1'b0);
    end
    $display("test field_codes done");
    for (int r = 0; r < 24; r++) begin
      slow <= r[0];
      wr(r % 3, 16'($urandom), 2'($urandom));
      chk_word(r % 3);
      irq_phase(8, 1'b0);
    end
    $display("test random_traffic done");
    // sources keep moving while ce is low; the outputs must not follow
    @(posedge clk_sys);
    ce <= 1'b0;
    @(negedge clk_sys);
    hold = {srcLevel, srcActive};
    repeat (6) begin
      @(posedge clk_sys);
      reqPat <= 24'($urandom);
      @(negedge clk_sys);
      chk_hold(hold);
    end
    @(posedge clk_sys);
    ce <= 1'b1;
    $display("test clock_enable done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
